/* File: shared/cfg_seq_regs.svh */
`ifndef CFG_SEQ_REGS_SVH
`define CFG_SEQ_REGS_SVH

// Reference clock period
`define CLK_PERIOD_NS      50
// Least low time on the reconfiguration reset, and its count
`define RESET_MIN_NS       320
`define RESET_MIN_CYC \
	((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Least wait from reset release to first data, in tenths of a microsecond
`define FIRST_DATA_TENTH_US 12
`define FIRST_DATA_CYC \
	((`FIRST_DATA_TENTH_US * 100 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Least user-entry delay after the completion flag
`define USER_MIN_US        25
`define USER_MIN_CYC \
	((`USER_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Divider ratios of the generated configuration clock
`define DIV_QUARTER        4
`define DIV_EIGHTH         8
// Bits the leading chain device keeps clocking after its flag
`define LEAD_CHAIN_BITS    1344

`endif

/* File: shared/cfg_seq_pkg.sv */
`default_nettype none
package cfg_seq_pkg;

	// Lane count code: lanes = 1 << code
	typedef enum logic [2:0]
	{
		W_X1,
		W_X2,
		W_X4,
		W_X8,
		W_X16,
		W_X32
	} bus_width_t;

	typedef enum logic [2:0]
	{
		ST_HOLD,
		ST_DELAY,
		ST_LOAD,
		ST_DRAIN,
		ST_LEAD,
		ST_USER_WAIT,
		ST_USER
	} seq_state_t;

endpackage
`default_nettype wire

/* File: rtl/fpga_config_timing_sequencer.sv */
`include "cfg_seq_regs.svh"
`default_nettype none
module fpga_config_timing_sequencer
#(
	parameter int DATA_W     = 32,
	parameter int LOAD_WORDS = 16
)
(
	input  wire logic                    ref_clk_i,
	input  wire logic                    rst_n_i,
	input  wire logic                    creset_n_i,
	input  wire logic                    active_mode_i,
	input  wire logic                    jtag_mode_i,
	input  wire logic                    eighth_rate_i,
	input  wire logic                    chain_narrow_i,
	input  wire logic                    lead_device_i,
	input  wire cfg_seq_pkg::bus_width_t bus_width_i,
	input  wire logic                    host_clk_i,
	input  wire logic [DATA_W-1:0]       cfg_data_i,
	input  wire logic                    user_entry_instr_i,
	input  wire logic                    word_ready_i,
	output logic                         config_clock_o,
	output logic                         config_complete_flag_o,
	output logic                         user_mode_o,
	output logic                         word_valid_o,
	output logic [DATA_W-1:0]            word_data_o,
	output logic                         buffer_full_o
);
	import cfg_seq_pkg::*;

	// All checks run on the one reference clock
	default clocking chk_cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	seq_state_t        state_ff;
	logic [10:0]       cnt_ff;
	logic [3:0]        low_cnt_ff;
	logic              creset_s1_ff;
	logic              creset_s2_ff;
	logic              host_s1_ff;
	logic              host_s2_ff;
	logic              host_s3_ff;
	logic [DATA_W-1:0] data_s1_ff;
	logic [DATA_W-1:0] data_s2_ff;
	logic              cclk_ff;
	logic [2:0]        div_cnt_ff;
	logic              flag_ff;
	logic              user_mode_ff;
	logic              instr_seen_ff;
	logic              out_valid_ff;
	logic [DATA_W-1:0] out_data_ff;
	logic              skid_valid_ff;
	logic [DATA_W-1:0] skid_data_ff;
	logic              hold_trig;
	logic              eff_eighth;
	logic [2:0]        div_half;
	logic              clk_run;
	logic              div_rise;
	logic              host_rise;
	logic              cclk_rise;
	logic              in_ready;
	logic              push;
	logic [10:0]       lead_target;

	// Pin inputs: two flops before any logic reads them
	always_ff @(posedge ref_clk_i)
	begin
		creset_s1_ff <= creset_n_i;
		creset_s2_ff <= creset_s1_ff;
		host_s1_ff   <= host_clk_i;
		host_s2_ff   <= host_s1_ff;
		host_s3_ff   <= host_s2_ff;
		data_s1_ff   <= cfg_data_i;
		data_s2_ff   <= data_s1_ff;
	end

	// Low-time counter; a glitch shorter than the least pulse is ignored
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i || creset_s2_ff)
			low_cnt_ff <= 4'h0;
		else if (low_cnt_ff != 4'(`RESET_MIN_CYC))
			low_cnt_ff <= low_cnt_ff + 4'h1;
	end

	assign hold_trig = !creset_s2_ff
		&& (low_cnt_ff == 4'(`RESET_MIN_CYC - 1));

	// Divider select; narrow parallel chains never run at eighth rate
	assign eff_eighth = eighth_rate_i && !chain_narrow_i;
	assign div_half   = eff_eighth ? 3'(`DIV_EIGHTH / 2)
		: 3'(`DIV_QUARTER / 2);
	assign in_ready   = !skid_valid_ff;
	// Clock pauses while the buffer is full, so a flash word is never lost
	assign clk_run    = active_mode_i
		&& (((state_ff == ST_LOAD) && in_ready) || (state_ff == ST_LEAD));
	assign div_rise   = clk_run && !cclk_ff && (div_cnt_ff == div_half - 3'h1);
	assign host_rise  = host_s2_ff && !host_s3_ff;
	assign cclk_rise  = active_mode_i ? div_rise : host_rise;
	assign push       = cclk_rise && (state_ff == ST_LOAD) && in_ready;
	assign lead_target = 11'(`LEAD_CHAIN_BITS) >> bus_width_i;

	// Generated configuration clock for active mode
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			cclk_ff    <= 1'b0;
			div_cnt_ff <= 3'h0;
		end
		else if (clk_run)
		begin
			if (div_cnt_ff == div_half - 3'h1)
			begin
				cclk_ff    <= !cclk_ff;
				div_cnt_ff <= 3'h0;
			end
			else
				div_cnt_ff <= div_cnt_ff + 3'h1;
		end
		else if (state_ff != ST_LOAD)
		begin
			cclk_ff    <= 1'b0;
			div_cnt_ff <= 3'h0;
		end
	end

	// Sequencer: hold, first-data wait, load, drain, lead clocks, user delay
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			state_ff <= ST_DELAY;
			cnt_ff   <= 11'h000;
		end
		else if (hold_trig)
		begin
			state_ff <= ST_HOLD;
			cnt_ff   <= 11'h000;
		end
		else
		begin
			unique case (state_ff)
				ST_HOLD:
					if (creset_s2_ff)
						state_ff <= ST_DELAY;
				ST_DELAY:
					if (cnt_ff == 11'(`FIRST_DATA_CYC - 1))
					begin
						state_ff <= ST_LOAD;
						cnt_ff   <= 11'h000;
					end
					else
						cnt_ff <= cnt_ff + 11'h001;
				ST_LOAD:
					if (push)
					begin
						if (cnt_ff == 11'(LOAD_WORDS - 1))
						begin
							state_ff <= ST_DRAIN;
							cnt_ff   <= 11'h000;
						end
						else
							cnt_ff <= cnt_ff + 11'h001;
					end
				ST_DRAIN:
					// Flag waits until the receiver has every word
					if (!out_valid_ff && !skid_valid_ff)
						state_ff <= lead_device_i ? ST_LEAD : ST_USER_WAIT;
				ST_LEAD:
					if (cclk_rise)
					begin
						if (cnt_ff == lead_target - 11'h001)
						begin
							state_ff <= ST_USER_WAIT;
							cnt_ff   <= 11'h000;
						end
						else
							cnt_ff <= cnt_ff + 11'h001;
					end
				ST_USER_WAIT:
					if (jtag_mode_i && !instr_seen_ff)
						cnt_ff <= 11'h000;
					else if (cnt_ff == 11'(`USER_MIN_CYC - 1))
						state_ff <= ST_USER;
					else
						cnt_ff <= cnt_ff + 11'h001;
				ST_USER:
					;
			endcase
		end
	end

	// Completion flag and user mode; both drop on a reconfiguration
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i || hold_trig)
		begin
			flag_ff      <= 1'b0;
			user_mode_ff <= 1'b0;
		end
		else
		begin
			if (state_ff == ST_DRAIN && !out_valid_ff && !skid_valid_ff)
				flag_ff <= 1'b1;
			if (state_ff == ST_USER_WAIT && cnt_ff == 11'(`USER_MIN_CYC - 1)
				&& !(jtag_mode_i && !instr_seen_ff))
				user_mode_ff <= 1'b1;
		end
	end

	// User-entry instruction latch; a set in the clearing cycle wins
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
			instr_seen_ff <= 1'b0;
		else if (user_entry_instr_i && jtag_mode_i)
			instr_seen_ff <= 1'b1;
		else if (hold_trig)
			instr_seen_ff <= 1'b0;
	end

	// Two-entry skid buffer; outputs come straight from its flops
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i || state_ff == ST_HOLD)
		begin
			out_valid_ff  <= 1'b0;
			skid_valid_ff <= 1'b0;
			out_data_ff   <= '0;
			skid_data_ff  <= '0;
		end
		else if (word_ready_i || !out_valid_ff)
		begin
			if (skid_valid_ff)
			begin
				out_data_ff   <= skid_data_ff;
				out_valid_ff  <= 1'b1;
				skid_valid_ff <= push;
				skid_data_ff  <= data_s2_ff;
			end
			else
			begin
				out_valid_ff <= push;
				out_data_ff  <= push ? data_s2_ff : out_data_ff;
			end
		end
		else if (push)
		begin
			skid_data_ff  <= data_s2_ff;
			skid_valid_ff <= 1'b1;
		end
	end

	assign config_clock_o         = cclk_ff;
	assign config_complete_flag_o = flag_ff;
	assign user_mode_o            = user_mode_ff;
	assign word_valid_o           = out_valid_ff;
	assign word_data_o            = out_data_ff;
	assign buffer_full_o          = skid_valid_ff;

	// Helper counters for the delay and lead-edge checks, saturating
	logic [10:0] since_flag_ff;
	logic [10:0] since_instr_ff;
	logic [10:0] lead_edges_ff;

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i || !flag_ff)
			since_flag_ff <= 11'h000;
		else if (since_flag_ff != 11'h7FF)
			since_flag_ff <= since_flag_ff + 11'h001;
		if (!rst_n_i || !instr_seen_ff)
			since_instr_ff <= 11'h000;
		else if (since_instr_ff != 11'h7FF)
			since_instr_ff <= since_instr_ff + 11'h001;
		if (!rst_n_i || !flag_ff)
			lead_edges_ff <= 11'h000;
		else if (cclk_rise && lead_edges_ff != 11'h7FF)
			lead_edges_ff <= lead_edges_ff + 11'h001;
	end

	sequence quarter_high_s;
		$rose(cclk_ff) && clk_run && !eff_eighth
			##1 clk_run && !eff_eighth;
	endsequence

	sequence eighth_high_s;
		$rose(cclk_ff) ##0 (clk_run && eff_eighth)[*4];
	endsequence

	chk_reset_restart: assert property (
		(!creset_s2_ff)[*7] |=> (state_ff == ST_HOLD) && !flag_ff)
		else $error("long reset pulse did not restart loading");
	chk_user_min: assert property (
		$rose(user_mode_ff) |-> since_flag_ff >= 11'(`USER_MIN_CYC))
		else $error("user mode came before the least delay");
	chk_mode_gate: assert property (
		$rose(user_mode_ff) |-> flag_ff && $past(state_ff) == ST_USER_WAIT)
		else $error("user mode without a finished delay");
	chk_jtag_later: assert property (
		$rose(user_mode_ff) && jtag_mode_i
			|-> since_instr_ff >= 11'(`USER_MIN_CYC))
		else $error("user delay not counted from the instruction");
	chk_quarter_rate: assert property (
		quarter_high_s |=> !cclk_ff)
		else $error("quarter-rate high phase wrong length");
	chk_eighth_rate: assert property (
		eighth_high_s |=> !cclk_ff)
		else $error("eighth-rate high phase wrong length");
	chk_first_data: assert property (
		state_ff == ST_LOAD && $past(state_ff) == ST_DELAY
			|-> $past(cnt_ff) == 11'(`FIRST_DATA_CYC - 1))
		else $error("data taken before the first-data delay");
	chk_chain_quarter: assert property (
		$rose(cclk_ff) && chain_narrow_i && clk_run
			##1 chain_narrow_i && clk_run |=> !cclk_ff)
		else $error("narrow chain not at quarter rate");
	chk_lead_edges: assert property (
		$rose(user_mode_ff) && lead_device_i |-> lead_edges_ff >= lead_target)
		else $error("leading device gave too few clock edges");
	chk_word_held: assert property (
		word_valid_o && !word_ready_i && state_ff != ST_HOLD
			|=> word_valid_o && $stable(word_data_o))
		else $error("stalled word changed or vanished");

endmodule
`default_nettype wire

/* File: tb/cfg_host_model.sv */
`default_nettype none
module cfg_host_model
(
	input  wire logic        ref_clk_i,
	input  wire logic        creset_n_i,
	input  wire logic        active_mode_i,
	input  wire logic        run_i,
	input  wire logic        config_clock_i,
	output logic             host_clk_o,
	output logic [31:0]      cfg_data_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [31:0] idx = 32'h0;
	logic [1:0]  div = 2'h0;
	logic        cc_q = 1'b0;
	logic        hclk = 1'b0;

	// Host clock: 4 cycles high, 4 low, 2.5 MHz; still outside frames
	always @(posedge ref_clk_i)
	begin
		cc_q <= config_clock_i;
		if (!creset_n_i || !run_i || active_mode_i)
		begin
			div <= 2'h0;
			hclk <= 1'b0;
		end
		else
		begin
			div <= div + 2'h1;
			if (div == 2'h3)
				hclk <= ~hclk;
		end
	end

	// Flash shifts after a clock rise; host changes data on its fall
	always @(posedge ref_clk_i)
	begin
		if (!creset_n_i)
			idx <= 32'h0;
		else if (active_mode_i && config_clock_i && !cc_q)
			idx <= idx + 32'h1;
		else if (!active_mode_i && hclk && div == 2'h3)
			idx <= idx + 32'h1;
	end

	// Released bus shows the inverse so a stale word cannot pass
	assign host_clk_o = hclk;
	assign cfg_data_o = (active_mode_i || run_i) ? 32'hC35A0000 + idx
		: ~(32'hC35A0000 + idx);
endmodule
`default_nettype wire

/* File: tb/fpga_config_timing_sequencer_tb.sv */
`include "cfg_seq_regs.svh"
`default_nettype none
module fpga_config_timing_sequencer_tb
	import cfg_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int          NW  = 4;
	localparam logic [31:0] PAT = 32'hC35A0000;
	logic        ref_clk_i = 1'b0, rst_n_i = 1'b0, creset_n_i = 1'b1;
	logic        active_mode_i = 1'b1, jtag_mode_i = 1'b0, run = 1'b0;
	logic        eighth_rate_i = 1'b0, chain_narrow_i = 1'b0;
	logic        lead_device_i = 1'b0, user_entry_instr_i = 1'b0;
	logic        word_ready_i = 1'b1;
	bus_width_t  bus_width_i = W_X1;
	logic        host_clk_i, config_clock_o, config_complete_flag_o;
	logic        user_mode_o, word_valid_o, buffer_full_o;
	logic [31:0] cfg_data_i, word_data_o;
	logic        cc_q = 0, fl_q = 0, um_q = 0, full_seen = 0;
	int          cyc = 0, rises = 0, gap = 0, last_rise = 0;
	int          f_cyc = -1, u_cyc = -1, i_cyc = -1;
	int          miscompares = 0, num_checks = 0;
	logic [31:0] got[$];

	always #25 ref_clk_i = ~ref_clk_i;

	fpga_config_timing_sequencer #(.DATA_W(32), .LOAD_WORDS(NW))
		u_fpga_config_timing_sequencer (.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i), .creset_n_i(creset_n_i),
		.active_mode_i(active_mode_i), .jtag_mode_i(jtag_mode_i),
		.eighth_rate_i(eighth_rate_i), .chain_narrow_i(chain_narrow_i),
		.lead_device_i(lead_device_i), .bus_width_i(bus_width_i),
		.host_clk_i(host_clk_i), .cfg_data_i(cfg_data_i),
		.user_entry_instr_i(user_entry_instr_i),
		.word_ready_i(word_ready_i), .config_clock_o(config_clock_o),
		.config_complete_flag_o(config_complete_flag_o),
		.user_mode_o(user_mode_o), .word_valid_o(word_valid_o),
		.word_data_o(word_data_o), .buffer_full_o(buffer_full_o));

	cfg_host_model u_cfg_host_model (.ref_clk_i(ref_clk_i),
		.creset_n_i(creset_n_i), .active_mode_i(active_mode_i),
		.run_i(run), .config_clock_i(config_clock_o),
		.host_clk_o(host_clk_i), .cfg_data_o(cfg_data_i));

	// Event log in clock cycles; also cuts a hang short
	always @(posedge ref_clk_i)
	begin
		cyc = cyc + 1;
		if (word_valid_o === 1'b1 && word_ready_i)
			got.push_back(word_data_o);
		if (config_clock_o === 1'b1 && !cc_q)
		begin
			gap = cyc - last_rise;
			last_rise = cyc;
			rises = rises + 1;
		end
		if (config_complete_flag_o === 1'b1 && !fl_q && f_cyc < 0)
			f_cyc = cyc;
		if (user_mode_o === 1'b1 && !um_q && u_cyc < 0)
			u_cyc = cyc;
		if (user_entry_instr_i)
			i_cyc = cyc;
		if (buffer_full_o === 1'b1)
			full_seen = 1'b1;
		cc_q = (config_clock_o === 1'b1);
		fl_q = (config_complete_flag_o === 1'b1);
		um_q = (user_mode_o === 1'b1);
		if (cyc > 60000)
		begin
			miscompares++;
			complete_run();
		end
	end

	task automatic check(input string what, input logic [31:0] lo,
		input logic [31:0] hi, input logic [31:0] seen);
		num_checks++;
		if ((seen >= lo && seen <= hi) !== 1'b1)
		begin
			miscompares++;
			$display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, seen);
		end
	endtask

	task automatic wait_ev(ref int ev);
		int k;
		k = 0;
		while (ev < 0 && k < 4000)
		begin
			@(negedge ref_clk_i);
			k++;
		end
	endtask

	task automatic restart(input logic act, input logic jt, input int low);
		@(negedge ref_clk_i);
		active_mode_i = act;
		jtag_mode_i = jt;
		run = 1'b0;
		creset_n_i = 1'b0;
		repeat (low) @(negedge ref_clk_i);
		creset_n_i = 1'b1;
		got.delete();
		rises = 0;
		f_cyc = -1;
		u_cyc = -1;
		i_cyc = -1;
		full_seen = 1'b0;
	endtask

	// User-mode delay from an event, then every word in order
	task automatic tail(input int lo, input int hi, ref int from);
		wait_ev(u_cyc);
		check("user delay", lo, hi, u_cyc - from);
		check("word count", NW, NW, got.size());
		foreach (got[i])
			check("word data", PAT + i, PAT + i, got[i]);
	endtask

	task automatic t_active(input logic eighth, input logic narrow,
		input int per);
		eighth_rate_i = eighth;
		chain_narrow_i = narrow;
		restart(1'b1, 1'b0, 8);
		tail(`USER_MIN_CYC, `USER_MIN_CYC + 1, f_cyc);
		check("clock period", per, per, gap);
	endtask

	task automatic t_creset();
		creset_n_i = 1'b0;
		repeat (6) @(negedge ref_clk_i);
		creset_n_i = 1'b1;
		repeat (30) @(negedge ref_clk_i);
		check("short pulse flag", 1, 1, config_complete_flag_o);
		check("short pulse user", 1, 1, user_mode_o);
		restart(1'b1, 1'b0, 7);
		repeat (4) @(negedge ref_clk_i);
		check("restart flag", 0, 0, config_complete_flag_o);
		check("restart user", 0, 0, user_mode_o);
		tail(`USER_MIN_CYC, `USER_MIN_CYC + 1, f_cyc);
	endtask

	// Receiver stalls: active clock must halt, no word lost
	task automatic t_stall();
		int r0;
		word_ready_i = 1'b0;
		restart(1'b1, 1'b0, 8);
		repeat (80) @(negedge ref_clk_i);
		r0 = rises;
		repeat (20) @(negedge ref_clk_i);
		check("buffer full", 1, 1, full_seen);
		check("clock halted", r0, r0, rises);
		check("nothing taken", 0, 0, got.size());
		word_ready_i = 1'b1;
		tail(`USER_MIN_CYC, `USER_MIN_CYC + 1, f_cyc);
	endtask

	task automatic t_passive();
		restart(1'b0, 1'b0, 8);
		repeat (30) @(negedge ref_clk_i);
		check("no early word", 0, 0, got.size());
		run = 1'b1;
		tail(`USER_MIN_CYC, `USER_MIN_CYC + 1, f_cyc);
	endtask

	task automatic t_jtag(input logic late);
		restart(1'b0, 1'b1, 8);
		repeat (30) @(negedge ref_clk_i);
		run = 1'b1;
		if (late)
			wait_ev(f_cyc);
		repeat (late ? 100 : 10) @(negedge ref_clk_i);
		user_entry_instr_i = 1'b1;
		@(negedge ref_clk_i);
		user_entry_instr_i = 1'b0;
		if (late)
			tail(`USER_MIN_CYC, `USER_MIN_CYC + 1, i_cyc);
		else
			tail(`USER_MIN_CYC, `USER_MIN_CYC + 1, f_cyc);
	endtask

	// Leading chain device: extra clock rises before the user wait
	task automatic t_lead();
		bus_width_t wl[2];
		int         n;
		wl = '{W_X8, W_X32};
		lead_device_i = 1'b1;
		foreach (wl[k])
		begin
			bus_width_i = wl[k];
			n = `LEAD_CHAIN_BITS >> int'(wl[k]);
			restart(1'b1, 1'b0, 8);
			tail(`USER_MIN_CYC + `DIV_QUARTER * (n - 1),
				`USER_MIN_CYC + `DIV_QUARTER * n + 8, f_cyc);
		end
		lead_device_i = 1'b0;
	endtask

	task automatic complete_run();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		repeat (6) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		t_active(1'b0, 1'b0, `DIV_QUARTER);
		t_active(1'b1, 1'b0, `DIV_EIGHTH);
		t_active(1'b1, 1'b1, `DIV_QUARTER);
		t_creset();
		t_stall();
		t_passive();
		t_jtag(1'b0);
		t_jtag(1'b1);
		t_lead();
		complete_run();
	end
endmodule
`default_nettype wire
